// ===== verilog/flr_fault_regs.v
// Fault limit registers and over-temperature fault response engine
`timescale 1ns/1ps
`default_nettype none
`include "flr_consts.vh"

module flr_fault_regs
#(
    parameter TICK_CYCLES = `FLR_TICK_CYCLES
)
(
    // Clock and reset
    input  wire         clk,
    input  wire         nrst,
    // Command port from the management bus engine
    input  wire         cmd_wr,
    input  wire         cmd_rd,
    input  wire [7:0]   cmd_code,
    input  wire [15:0]  cmd_wdata,
    output reg  [15:0]  cmd_rdata,
    output reg          cmd_rvalid,
    output reg          cmd_err,
    // Measurements, same clock domain
    input  wire [15:0]  meas_current,
    input  wire [15:0]  meas_vout,
    input  wire [15:0]  meas_temp,
    // Output control
    input  wire         output_on_cmd,
    output reg          output_enable,
    output reg          oc_lv_fault,
    output reg          oc_warning,
    output reg          ot_fault
);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    reg  [15:0]  overcurrent_lowvolt_fault_threshold;
    reg  [15:0]  overcurrent_warning_threshold;
    reg  [15:0]  overtemp_fault_threshold;
    reg  [7:0]   overtemp_fault_action;
    reg  [7:0]   delay_unit;

    wire [1:0]   act   = overtemp_fault_action[`FLR_ACT_MSB:`FLR_ACT_LSB];
    wire [2:0]   retry = overtemp_fault_action[`FLR_RETRY_MSB:`FLR_RETRY_LSB];
    wire [2:0]   dly   = overtemp_fault_action[`FLR_DLY_MSB:`FLR_DLY_LSB];

    wire         wr_clear_all = cmd_wr && (cmd_code == `FLR_CMD_CLEAR_FAULTS);
    wire         wr_status    = cmd_wr && (cmd_code == `FLR_CMD_STATUS);

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            overcurrent_lowvolt_fault_threshold <= `FLR_RST_OC_LV_FAULT;
            overcurrent_warning_threshold       <= `FLR_RST_OC_WARN;
            overtemp_fault_threshold            <= `FLR_RST_OT_FAULT;
            overtemp_fault_action               <= `FLR_RST_OT_ACTION;
            delay_unit                          <= `FLR_RST_DELAY_UNIT;
        end
        else if (cmd_wr)
        begin
            case (cmd_code)
                `FLR_CMD_OC_LV_FAULT: overcurrent_lowvolt_fault_threshold <= cmd_wdata;
                `FLR_CMD_OC_WARN:     overcurrent_warning_threshold <= cmd_wdata;
                `FLR_CMD_OT_FAULT:    overtemp_fault_threshold <= cmd_wdata;
                `FLR_CMD_OT_ACTION:   overtemp_fault_action <= cmd_wdata[7:0];
                `FLR_CMD_DELAY_UNIT:  delay_unit <= cmd_wdata[7:0];
                default:              ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Read path and fault status
    // ---------------------------------------------------------------
    // Status word: bit0 over-temperature, bit1 over-current LV, bit2 warning
    wire [15:0] status_word = {13'h0000, oc_warning, oc_lv_fault, ot_fault};

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmd_rdata  <= 16'h0000;
            cmd_rvalid <= 1'b0;
            cmd_err    <= 1'b0;
        end
        else
        begin
            cmd_rvalid <= cmd_rd;
            cmd_err    <= 1'b0;
            if (cmd_rd)
            begin
                case (cmd_code)
                    `FLR_CMD_OC_LV_FAULT: cmd_rdata <= overcurrent_lowvolt_fault_threshold;
                    `FLR_CMD_OC_WARN:     cmd_rdata <= overcurrent_warning_threshold;
                    `FLR_CMD_OT_FAULT:    cmd_rdata <= overtemp_fault_threshold;
                    `FLR_CMD_OT_ACTION:   cmd_rdata <= {8'h00, overtemp_fault_action};
                    `FLR_CMD_DELAY_UNIT:  cmd_rdata <= {8'h00, delay_unit};
                    `FLR_CMD_STATUS:      cmd_rdata <= status_word;
                    default:
                    begin
                        cmd_rdata <= 16'h0000;
                        cmd_err   <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Limit comparison
    // ---------------------------------------------------------------
    // Low-voltage over-current: excess current while vout is under threshold
    wire oc_lv_cond = (meas_current > overcurrent_warning_threshold)
                      && (meas_vout < overcurrent_lowvolt_fault_threshold);
    wire warn_cond  = (meas_current > overcurrent_warning_threshold);
    wire ot_cond    = (meas_temp > overtemp_fault_threshold);

    // Off/on cycle of the output command clears latched faults
    reg  on_cmd_d;
    wire on_rise = output_on_cmd && !on_cmd_d;

    wire clr_ot  = wr_clear_all || on_rise || (wr_status && cmd_wdata[0]);
    wire clr_lv  = wr_clear_all || on_rise || (wr_status && cmd_wdata[1]);
    wire clr_wrn = wr_clear_all || on_rise || (wr_status && cmd_wdata[2]);

    // ---------------------------------------------------------------
    // Response engine
    // ---------------------------------------------------------------
    localparam [4:0] ST_RUN    = 5'b00001;
    localparam [4:0] ST_HOLD   = 5'b00010;
    localparam [4:0] ST_WAIT   = 5'b00100;
    localparam [4:0] ST_TRY    = 5'b01000;
    localparam [4:0] ST_LATCH  = 5'b10000;

    reg  [4:0]   state;
    reg  [7:0]   unit_cnt;
    reg  [2:0]   tries;
    wire         unit_tick;
    wire [7:0]   dly_units = 8'h01 << dly;
    wire         timer_clr = (state == ST_RUN) || (state == ST_LATCH);

    flr_unit_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer
    (
        .clk       (clk),
        .nrst      (nrst),
        .clear     (timer_clr),
        .unit_len  (delay_unit),
        .unit_tick (unit_tick)
    );

    wire delay_done = unit_tick && (unit_cnt + 8'h01 >= dly_units);
    // Retry budget left; 111 never runs out
    wire can_retry  = (retry == `FLR_RETRY_FOREVER) || (tries < retry);

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state         <= ST_RUN;
            unit_cnt      <= 8'h00;
            tries         <= 3'h0;
            output_enable <= 1'b0;
            // Starts high so a command already on at reset is not seen as a rise
            on_cmd_d      <= 1'b1;
            ot_fault      <= 1'b0;
            oc_lv_fault   <= 1'b0;
            oc_warning    <= 1'b0;
        end
        else
        begin
            on_cmd_d <= output_on_cmd;
            // Set wins over clear for every latched flag
            ot_fault    <= ot_cond    | (ot_fault    & ~clr_ot);
            oc_lv_fault <= oc_lv_cond | (oc_lv_fault & ~clr_lv);
            oc_warning  <= warn_cond  | (oc_warning  & ~clr_wrn);
            if (state == ST_WAIT || state == ST_HOLD)
                unit_cnt <= delay_done ? 8'h00 : unit_cnt + {7'h00, unit_tick};
            else
                unit_cnt <= 8'h00;
            case (state)
                ST_RUN:
                begin
                    output_enable <= output_on_cmd;
                    tries         <= 3'h0;
                    if (output_on_cmd && ot_cond)
                    begin
                        case (act)
                            `FLR_ACT_IGNORE:  ;
                            `FLR_ACT_DELAYED: state <= ST_HOLD;
                            `FLR_ACT_DISABLE_RETRY:
                            begin
                                output_enable <= 1'b0;
                                state <= (retry == `FLR_RETRY_NONE) ? ST_LATCH : ST_WAIT;
                            end
                            default:
                            begin
                                output_enable <= 1'b0;
                                state         <= ST_LATCH;
                            end
                        endcase
                    end
                end
                ST_HOLD:
                begin
                    // Keep running through the delay; a vanished fault ends it
                    output_enable <= output_on_cmd;
                    if (!ot_cond || !output_on_cmd)
                        state <= ST_RUN;
                    else if (delay_done)
                    begin
                        output_enable <= 1'b0;
                        state <= (retry == `FLR_RETRY_NONE) ? ST_LATCH : ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    output_enable <= 1'b0;
                    if (!output_on_cmd)
                        state <= ST_RUN;
                    else if (delay_done)
                        state <= can_retry ? ST_TRY : ST_LATCH;
                end
                ST_TRY:
                begin
                    // One restart attempt; never re-enables against an off command
                    output_enable <= output_on_cmd;
                    if (tries != 3'h7)
                        tries <= tries + 3'h1;
                    state <= ST_WAIT;
                    if (!ot_cond)
                        state <= ST_RUN;
                end
                ST_LATCH:
                begin
                    output_enable <= 1'b0;
                    if (clr_ot)
                        state <= ST_RUN;
                end
                default:
                    state <= ST_RUN;
            endcase
        end
    end

endmodule
`default_nettype wire

// ===== inc/flr_consts.vh
// Command codes, field positions, reset values and timing of the fault limit and response block
`ifndef FLR_CONSTS_VH
`define FLR_CONSTS_VH

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define FLR_CMD_OC_LV_FAULT     8'h48
`define FLR_CMD_OC_WARN         8'h4A
`define FLR_CMD_OT_FAULT        8'h4F
`define FLR_CMD_OT_ACTION       8'h50
`define FLR_CMD_DELAY_UNIT      8'hD2
`define FLR_CMD_CLEAR_FAULTS    8'h03
`define FLR_CMD_STATUS          8'h7D

// ---------------------------------------------------------------
// Action byte fields
// ---------------------------------------------------------------
`define FLR_ACT_MSB             7
`define FLR_ACT_LSB             6
`define FLR_RETRY_MSB           5
`define FLR_RETRY_LSB           3
`define FLR_DLY_MSB             2
`define FLR_DLY_LSB             0

`define FLR_ACT_IGNORE          2'h0
`define FLR_ACT_DELAYED         2'h1
`define FLR_ACT_DISABLE_RETRY   2'h2
`define FLR_ACT_LATCH_OFF       2'h3

`define FLR_RETRY_NONE          3'h0
`define FLR_RETRY_FOREVER       3'h7

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define FLR_RST_OC_LV_FAULT     16'hFFFF
`define FLR_RST_OC_WARN         16'hFFFF
`define FLR_RST_OT_FAULT        16'hFFFF
`define FLR_RST_OT_ACTION       8'h80
`define FLR_RST_DELAY_UNIT      8'h01

// ---------------------------------------------------------------
// Timing: one unit tick is 1 us of the 10 MHz clock times the unit register
// ---------------------------------------------------------------
`define FLR_CLK_NS              100
`define FLR_TICK_NS             1000
`define FLR_TICK_CYCLES         (`FLR_TICK_NS / `FLR_CLK_NS)

`endif

// ===== verilog/flr_unit_timer.v
// Delay unit tick generator: one pulse per delay time unit
`timescale 1ns/1ps
`default_nettype none
`include "flr_consts.vh"

module flr_unit_timer
#(
    parameter TICK_CYCLES = `FLR_TICK_CYCLES
)
(
    // Clock and reset
    input  wire         clk,
    input  wire         nrst,
    // Control
    input  wire         clear,
    input  wire [7:0]   unit_len,
    // Output
    output reg          unit_tick
);

    reg  [15:0]  pre_cnt;
    reg  [7:0]   unit_cnt;
    wire         pre_done;

    assign pre_done = (pre_cnt == TICK_CYCLES[15:0] - 16'h0001);

    // A zero unit length is treated as one to keep the timer moving
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pre_cnt   <= 16'h0000;
            unit_cnt  <= 8'h00;
            unit_tick <= 1'b0;
        end
        else if (clear)
        begin
            pre_cnt   <= 16'h0000;
            unit_cnt  <= 8'h00;
            unit_tick <= 1'b0;
        end
        else
        begin
            unit_tick <= 1'b0;
            if (pre_done)
            begin
                pre_cnt <= 16'h0000;
                if (unit_cnt + 8'h01 >= unit_len)
                begin
                    unit_cnt  <= 8'h00;
                    unit_tick <= 1'b1;
                end
                else
                    unit_cnt <= unit_cnt + 8'h01;
            end
            else
                pre_cnt <= pre_cnt + 16'h0001;
        end
    end

endmodule
`default_nettype wire

// ===== test/flr_host.sv
// Host model issuing command cycles to the fault limit block
`timescale 1ns/1ps
`default_nettype none
module flr_host (
    // Clock
    input  wire logic        clk,
    // Command port
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_rvalid,
    input  wire logic        cmd_err
);
    logic [15:0] rdata;
    logic        vld;
    logic        err;
    // -----------------
    // Command cycles
    // -----------------
    // Idle code shows the inverse of the last value; data is inverted only after a write, a read leaves it stale
    initial
    begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk);
        #1;
        cmd_wr = 1'b1;
        cmd_code = c;
        cmd_wdata = d;
        @(posedge clk);
        #1;
        cmd_wr = 1'b0;
        cmd_code = ~c;
        cmd_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] c);
        @(posedge clk);
        #1;
        cmd_rd = 1'b1;
        cmd_code = c;
        @(posedge clk);
        #1;
        cmd_rd = 1'b0;
        cmd_code = ~c;
        vld = cmd_rvalid;
        rdata = cmd_rdata;
        err = cmd_err;
    endtask
    task automatic clr;
        wr(8'h03, 16'h0000);
    endtask
endmodule
`default_nettype wire

// ===== test/flr_fault_regs_assertions.sv
// Port checker of the fault limit and response block
`timescale 1ns/1ps
`default_nettype none
`include "flr_consts.vh"
module flr_fault_regs_chk (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Command port
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        cmd_rvalid,
    input  wire logic        cmd_err,
    // Measurements and output control
    input  wire logic [15:0] meas_current,
    input  wire logic [15:0] meas_temp,
    input  wire logic        output_on_cmd,
    input  wire logic        output_enable,
    input  wire logic        oc_warning,
    input  wire logic        ot_fault
);
    logic [15:0] ot_lim;
    logic [15:0] warn_lim;
    logic [7:0]  act;
    logic        clr_ok;
    // -----------------
    // Shadow registers
    // -----------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ot_lim <= `FLR_RST_OT_FAULT;
            warn_lim <= `FLR_RST_OC_WARN;
            act <= `FLR_RST_OT_ACTION;
        end
        else if (cmd_wr)
        begin
            if (cmd_code == `FLR_CMD_OT_FAULT) ot_lim <= cmd_wdata;
            if (cmd_code == `FLR_CMD_OC_WARN) warn_lim <= cmd_wdata;
            if (cmd_code == `FLR_CMD_OT_ACTION) act <= cmd_wdata[7:0];
        end
    end
    assign clr_ok = meas_temp <= ot_lim && meas_current <= warn_lim;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // -----------------
    // Assertions
    // -----------------
    a_read_answer: assert property (cmd_rd |=> cmd_rvalid)
        else $error("read not answered");
    a_rvalid_cause: assert property (cmd_rvalid |-> $past(cmd_rd))
        else $error("answer without read");
    a_mapped_ok: assert property (cmd_rd && (cmd_code == 8'h48 || cmd_code == 8'h4A ||
        cmd_code == 8'h4F || cmd_code == 8'h50) |=> !cmd_err) else $error("mapped read refused");
    a_ot_sets: assert property (meas_temp > ot_lim |=> ot_fault)
        else $error("temperature fault missed");
    a_warn_sets: assert property (meas_current > warn_lim |=> oc_warning)
        else $error("current warning missed");
    a_clear_all: assert property (cmd_wr && cmd_code == 8'h03 && clr_ok
        |=> !ot_fault && !oc_warning) else $error("clear-all left a flag");
    a_latch_off: assert property ((act[7:6] == 2'h3 && ot_fault) [*2]
        |=> !output_enable) else $error("latched fault left output on");
    a_no_retry: assert property ((act[7:3] == 5'b10000 && ot_fault) [*2]
        |=> !output_enable) else $error("no-retry fault left output on");
    a_off_follows: assert property (!output_on_cmd [*2] |-> !output_enable)
        else $error("output on while commanded off");
    a_ignore_runs: assert property ((act[7:6] == 2'h0 && output_on_cmd) [*3]
        |-> output_enable) else $error("ignored fault stopped output");
endmodule
`default_nettype wire

// ===== test/flr_fault_regs_bench.sv
// Self-checking bench of the fault limit and response block
`timescale 1ns/1ps
`default_nettype none
`include "flr_consts.vh"
module flr_fault_regs_bench;
    localparam int TICK = 2;
    logic        clk, nrst, on_cmd, cmd_wr, cmd_rd, rvalid, err, oen, lvf, warn, otf;
    logic [7:0]  code;
    logic [15:0] wdata, rdata, cur, vout, temp;
    int          errors, comparisons;
    flr_fault_regs #(.TICK_CYCLES(TICK)) dut_u (.clk(clk), .nrst(nrst), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_code(code), .cmd_wdata(wdata), .cmd_rdata(rdata),
        .cmd_rvalid(rvalid), .cmd_err(err), .meas_current(cur), .meas_vout(vout),
        .meas_temp(temp), .output_on_cmd(on_cmd), .output_enable(oen), .oc_lv_fault(lvf),
        .oc_warning(warn), .ot_fault(otf));
    flr_host host_u (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(code),
        .cmd_wdata(wdata), .cmd_rdata(rdata), .cmd_rvalid(rvalid), .cmd_err(err));
    // -----------------
    // Helpers
    // -----------------
    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        chk16(n, {15'h0, e}, {15'h0, g});
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
        host_u.rd(c);
        chk1("rvalid", 1'b1, host_u.vld);
        chk16("rdata", e, host_u.rdata);
    endtask
    // Off/on cycle with the fault gone leaves the engine running again
    task automatic restart;
        temp = 16'd0;
        on_cmd = 1'b0;
        step(2);
        on_cmd = 1'b1;
        step(3);
    endtask
    task automatic wait_rise(output int n);
        logic p;
        p = oen;
        n = 0;
        repeat (1000)
        begin
            step(1);
            n++;
            if (oen && !p) break;
            p = oen;
        end
    endtask
    // -----------------
    // Scenarios
    // -----------------
    task automatic t_regs;
        logic [7:0]  c [4];
        logic [15:0] r [4];
        logic [15:0] d;
        c = '{`FLR_CMD_OC_LV_FAULT, `FLR_CMD_OC_WARN, `FLR_CMD_OT_FAULT, `FLR_CMD_OT_ACTION};
        r = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0080};
        foreach (c[i])
        begin
            rd_chk(c[i], r[i]);
            d = 16'hA5C3 ^ 16'(i);
            host_u.wr(c[i], d);
            rd_chk(c[i], (i == 3) ? {8'h00, d[7:0]} : d);
        end
        host_u.rd(8'h20);
        chk1("error", 1'b1, host_u.err);
        chk16("unmapped", 16'h0000, host_u.rdata);
    endtask
    task automatic t_warn;
        host_u.wr(`FLR_CMD_OC_WARN, 16'd100);
        host_u.wr(`FLR_CMD_OC_LV_FAULT, 16'd50);
        vout = 16'd10;
        cur = 16'd200;
        step(2);
        cur = 16'd0;
        chk1("warning", 1'b1, warn);
        chk1("lowvolt", 1'b1, lvf);
        rd_chk(`FLR_CMD_STATUS, 16'h0006);
        host_u.wr(`FLR_CMD_STATUS, 16'h0004);
        chk1("warning", 1'b0, warn);
        chk1("lowvolt", 1'b1, lvf);
        host_u.clr();
        chk1("lowvolt", 1'b0, lvf);
        vout = 16'hFFFF;
    endtask
    task automatic t_ignore;
        host_u.wr(`FLR_CMD_OT_FAULT, 16'd300);
        host_u.wr(`FLR_CMD_OT_ACTION, 16'h0000);
        temp = 16'd400;
        step(10);
        chk1("fault", 1'b1, otf);
        chk1("enable", 1'b1, oen);
        temp = 16'd0;
        host_u.clr();
    endtask
    task automatic t_latch;
        host_u.wr(`FLR_CMD_OT_ACTION, 16'h00C0);
        temp = 16'd400;
        step(3);
        temp = 16'd0;
        step(20);
        chk1("enable", 1'b0, oen);
        host_u.clr();
        step(3);
        chk1("fault", 1'b0, otf);
        chk1("enable", 1'b1, oen);
        temp = 16'd400;
        step(3);
        restart();
        chk1("fault", 1'b0, otf);
        chk1("enable", 1'b1, oen);
        temp = 16'd400;
        step(3);
        nrst = 1'b0;
        step(1);
        nrst = 1'b1;
        temp = 16'd0;
        chk1("fault", 1'b0, otf);
    endtask
    task automatic t_retry;
        logic [2:0] r [6];
        logic       p;
        int         n;
        r = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
        host_u.wr(`FLR_CMD_OT_FAULT, 16'd300);
        foreach (r[i])
        begin
            host_u.wr(`FLR_CMD_OT_ACTION, {8'h00, 2'h2, r[i], 3'h0});
            chk1("enable", 1'b1, oen);
            temp = 16'd400;
            step(3);
            chk1("enable", 1'b0, oen);
            n = 0;
            p = 1'b0;
            repeat (300)
            begin
                step(1);
                if (oen && !p) n++;
                p = oen;
            end
            if (r[i] == 3'h7) chk1("unlimited", 1'b1, n > 20);
            else chk16("attempts", {13'h0, r[i]}, n[15:0]);
            restart();
        end
    endtask
    task automatic t_space;
        logic [2:0] d [3];
        logic [7:0] u [3];
        int         n;
        d = '{3'h0, 3'h3, 3'h7};
        u = '{8'h01, 8'h02, 8'h01};
        foreach (d[i])
        begin
            host_u.wr(`FLR_CMD_DELAY_UNIT, {8'h00, u[i]});
            rd_chk(`FLR_CMD_DELAY_UNIT, {8'h00, u[i]});
            host_u.wr(`FLR_CMD_OT_ACTION, {8'h00, 5'b10111, d[i]});
            temp = 16'd400;
            wait_rise(n);
            wait_rise(n);
            chk16("spacing", 16'((TICK * u[i]) << d[i]), n[15:0]);
            restart();
        end
    endtask
    task automatic t_delay;
        host_u.wr(`FLR_CMD_DELAY_UNIT, 16'h0001);
        host_u.wr(`FLR_CMD_OT_ACTION, 16'h0043);
        temp = 16'd400;
        step(12);
        chk1("enable", 1'b1, oen);
        step(20);
        chk1("enable", 1'b0, oen);
        restart();
    endtask
    task automatic stop_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // -----------------
    // Run
    // -----------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Whole run is about 2600 cycles; the limit leaves ample margin
    initial
    begin
        #2000000;
        errors++;
        $display("[ERR] watchdog expected finish seen hang");
        stop_test();
    end
    initial
    begin
        nrst = 1'b0;
        on_cmd = 1'b1;
        cur = 16'd0;
        vout = 16'hFFFF;
        temp = 16'd0;
        errors = 0;
        comparisons = 0;
        step(4);
        nrst = 1'b1;
        t_regs();
        $display("test regs done");
        t_warn();
        $display("test warn done");
        t_ignore();
        $display("test ignore done");
        t_latch();
        $display("test latch done");
        t_retry();
        $display("test retry done");
        t_space();
        $display("test space done");
        t_delay();
        $display("test delay done");
        stop_test();
    end
endmodule
bind flr_fault_regs flr_fault_regs_chk chk_u (.clk(clk), .nrst(nrst), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rvalid(cmd_rvalid),
    .cmd_err(cmd_err), .meas_current(meas_current), .meas_temp(meas_temp),
    .output_on_cmd(output_on_cmd), .output_enable(output_enable), .oc_warning(oc_warning),
    .ot_fault(ot_fault));
`default_nettype wire
